/* spicd_checker.sv */
`timescale 1ns/1ps
// =====================================================================
// port checks; control and divider are shadowed from completed writes
module spicd_checker #(
  parameter int DIV_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic sclkOut,
  input wire logic sclkOen_b,
  input wire logic mosiOen_b,
  input wire logic misoOut,
  input wire logic misoOen_b,
  input wire logic csOut_b,
  input wire logic csOen_b,
  input wire logic spiIrq
);
  logic [15:0] con;
  logic [15:0] conQ;
  logic [DIV_W-1:0] div;
  logic sclkQ;
  logic [15:0] gap;
  logic [15:0] hiCnt;
  logic [7:0] edgeCnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // =====================================================================
  // access decode; outputs lag a control write by one flop
  wire rdAcc = psel && penable && !pwrite;
  wire wrAcc = psel && penable && pwrite;
  wire conOk = con == conQ;
  wire sclkChg = sclkOut != sclkQ;
  wire [15:0] half = 16'(div) + 16'h1;
  // gap and idle counters saturate so a long idle cannot wrap into a false pass; the edge counter wraps
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      con <= 16'h0;
      conQ <= 16'h0;
      div <= DIV_W'(8'h1b);
      sclkQ <= 1'b0;
      gap <= 16'h0;
      hiCnt <= 16'hffff;
      edgeCnt <= 8'h0;
    end else begin
      conQ <= con;
      sclkQ <= sclkOut;
      if (wrAcc && paddr == spicd_pkg::ADDR_CON) con <= pwdata[15:0] & 16'h1fef;
      if (wrAcc && paddr == spicd_pkg::ADDR_DIV) div <= pwdata[DIV_W-1:0];
      gap <= sclkChg ? 16'h1 : gap + 16'(gap != 16'hffff);
      hiCnt <= !csOut_b ? 16'h0 : hiCnt + 16'(hiCnt != 16'hffff);
      edgeCnt <= csOut_b ? 8'h0 : edgeCnt + 8'(sclkChg);
    end
  end
  a_div_readback: assert property (
    rdAcc && paddr == spicd_pkg::ADDR_DIV |-> prdata == 32'(div))
    else $error("divider read differs");
  a_con_readback: assert property (
    rdAcc && paddr == spicd_pkg::ADDR_CON |-> prdata == {16'h0, con})
    else $error("control read differs");
  a_half_period: assert property (
    sclkChg && !csOut_b && edgeCnt[3:0] != 4'h0 |-> gap == half)
    else $error("serial half period wrong");
  a_off_quiet: assert property (
    conOk && !con[0] |-> csOut_b && sclkOen_b && mosiOen_b)
    else $error("disabled port drives");
  a_master_pins: assert property (
    conOk && con[0] && con[1] |-> !sclkOen_b && !mosiOen_b && misoOen_b)
    else $error("master pin drive wrong");
  a_sclk_rest: assert property (
    conOk && csOut_b && $past(csOut_b) |-> sclkOut == con[3])
    else $error("clock rest level wrong");
  a_frame_bits: assert property (
    $rose(csOut_b) |-> edgeCnt != 8'h0 && edgeCnt[3:0] == 4'h0)
    else $error("frame not whole bytes");
  a_stall_min: assert property (
    $fell(csOut_b) |-> hiCnt >= 2 * half)
    else $error("stall too short");
  a_cs_enable: assert property (
    conOk |-> csOen_b == !(con[0] && con[1] && !con[9]))
    else $error("select enable wrong");
  a_open_drain: assert property (
    conOk && con[10] |-> !misoOut)
    else $error("open drain drives high");
  a_irq_select: assert property (
    rdAcc && paddr == spicd_pkg::ADDR_STATUS && conOk
      |-> spiIrq == (con[0] && (con[6] ? prdata[1] : prdata[4])))
    else $error("interrupt source wrong");
  c_frame: cover property ($fell(csOut_b));
  c_irq: cover property (rdAcc && spiIrq);
  c_cont: cover property ($rose(csOut_b) && edgeCnt == 8'h20);
endmodule // spicd_checker

bind spicd_top spicd_checker #(.DIV_W(DIV_W)) chkr (.mclk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .sclkOut, .sclkOen_b, .mosiOen_b, .misoOut,
  .misoOen_b, .csOut_b, .csOen_b, .spiIrq);

/* spicd_clkgen.sv */
`timescale 1ns/1ps
// =====================================================================
// half-period tick generator: one pulse every (divisor+1) core cycles
module spicd_clkgen #(
  parameter int DIV_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  logic [DIV_W-1:0] count;
  wire atEnd = (count == divisor);

  // counter restarts while idle so the first half period is always full
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (!run || atEnd) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign tick = run & atEnd;
endmodule // spicd_clkgen

/* spicd_pkg.sv */
// =====================================================================
// shared constants of the serial port control block
package spicd_pkg;
  // =====================================================================
  // register byte addresses
  localparam logic [31:0] ADDR_STATUS = 32'hffff0a00;
  localparam logic [31:0] ADDR_RX = 32'hffff0a04;
  localparam logic [31:0] ADDR_TX = 32'hffff0a08;
  localparam logic [31:0] ADDR_DIV = 32'hffff0a0c;
  localparam logic [31:0] ADDR_CON = 32'hffff0a10;

  // =====================================================================
  // reset values
  localparam logic [7:0] DIV_RESET = 8'h1b;
  localparam logic [15:0] CON_RESET = 16'h0000;
  localparam logic [15:0] CON_WMASK = 16'h1fef;  // bits 15:13 and 4 stay zero

  // =====================================================================
  // control field positions
  localparam int CON_EN = 0;
  localparam int CON_MASTER = 1;
  localparam int CON_CPHA = 2;
  localparam int CON_CPOL = 3;
  localparam int CON_LSB = 5;
  localparam int CON_TXTRIG = 6;
  localparam int CON_UFZERO = 7;
  localparam int CON_OVWR = 8;
  localparam int CON_CSDIS = 9;
  localparam int CON_ODRAIN = 10;
  localparam int CON_LOOP = 11;
  localparam int CON_CONT = 12;

  // =====================================================================
  // status field positions
  localparam int STA_TXFULL = 0;
  localparam int STA_TXIRQ = 1;
  localparam int STA_TXUF = 2;
  localparam int STA_RXFULL = 3;
  localparam int STA_RXIRQ = 4;
  localparam int STA_RXOF = 5;

  // =====================================================================
  // timing: half-period ticks per byte and per stall
  localparam logic [3:0] BYTE_LAST_STEP = 4'hf;
  localparam logic [1:0] STALL_TICKS = 2'h2;  // one full serial clock period
endpackage

/* spicd_shift_if.sv */
`timescale 1ns/1ps
// =====================================================================
// link between the control logic and the shift engine
interface spicd_shift_if;
  logic start;
  logic abort;
  logic step;
  logic cpha;
  logic lsbFirst;
  logic dataIn;
  logic [7:0] txByte;
  logic busy;
  logic done;
  logic dataOut;
  logic clkPhase;
  logic [7:0] rxByte;

  modport ctrl (
    output start, abort, step, cpha, lsbFirst, dataIn, txByte,
    input busy, done, dataOut, clkPhase, rxByte
  );
  modport engine (
    input start, abort, step, cpha, lsbFirst, dataIn, txByte,
    output busy, done, dataOut, clkPhase, rxByte
  );
endinterface

/* spicd_shifter.sv */
`timescale 1ns/1ps
// =====================================================================
// 8-bit shift engine, stepped once per serial clock edge
module spicd_shifter (
  input wire logic mclk,
  input wire logic rst_b,
  spicd_shift_if.engine sh
);
  logic [3:0] stepCnt;
  logic [7:0] txShift;
  logic [7:0] rxShift;
  logic busyReg;
  logic doneReg;
  logic phaseReg;
  logic [7:0] rxOut;

  // even steps are leading edges, odd steps trailing edges
  wire leading = ~stepCnt[0];
  wire sampleNow = sh.step & busyReg & (sh.cpha ? ~leading : leading);
  wire shiftNow = sh.step & busyReg & (sh.cpha ? (leading & (stepCnt != 4'h0)) : ~leading);
  wire lastStep = sh.step & busyReg & (stepCnt == spicd_pkg::BYTE_LAST_STEP);
  wire [7:0] next_rx = sh.lsbFirst ? {sh.dataIn, rxShift[7:1]} : {rxShift[6:0], sh.dataIn};
  wire [7:0] next_tx = sh.lsbFirst ? {1'b0, txShift[7:1]} : {txShift[6:0], 1'b0};

  // step counter, busy and clock phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stepCnt <= 4'h0;
      busyReg <= 1'b0;
      doneReg <= 1'b0;
      phaseReg <= 1'b0;
    end else begin
      doneReg <= lastStep & ~sh.abort;
      if (sh.abort || lastStep) begin
        busyReg <= 1'b0;
        phaseReg <= 1'b0;
      end else if (sh.start) begin
        busyReg <= 1'b1;
        stepCnt <= 4'h0;
        phaseReg <= 1'b0;
      end else if (sh.step && busyReg) begin
        stepCnt <= stepCnt + 4'h1;
        phaseReg <= ~phaseReg;
      end
    end
  end

  // data registers; first bit is on the line from the moment of loading
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txShift <= 8'h00;
      rxShift <= 8'h00;
      rxOut <= 8'h00;
    end else begin
      if (sh.start && !busyReg) txShift <= sh.txByte;
      else if (shiftNow) txShift <= next_tx;
      if (sampleNow) rxShift <= next_rx;
      if (lastStep) rxOut <= sampleNow ? next_rx : rxShift;
    end
  end

  assign sh.busy = busyReg;
  assign sh.done = doneReg;
  assign sh.clkPhase = phaseReg;
  assign sh.rxByte = rxOut;
  assign sh.dataOut = sh.lsbFirst ? txShift[0] : txShift[7];
endmodule // spicd_shifter

/* spicd_slave_model.sv */
`timescale 1ns/1ps
// =====================================================================
// far-side slave for all four clock modes; smpFall high samples on falling edges
module spicd_slave_model (
  input wire logic sclk,
  input wire logic csB,
  input wire logic mosi,
  input wire logic smpFall,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got,
  output int bits
);
  logic [7:0] sh;
  logic csQ;
  logic sclkQ;
  // one process owns every model variable, so each has a single driver
  always @(csB or sclk) begin
    if (csB !== csQ && csB === 1'b0) begin
      // a frame opens with the first reply bit already on the line
      sh = reply;
      miso = reply[7];
      bits = 0;
    end else if (csB !== csQ) begin
      // released line shows the inverse so a stale bit cannot match by luck
      miso = ~miso;
    end else if (csB === 1'b0 && sclk !== sclkQ && sclk === ~smpFall) begin
      got = {got[6:0], mosi};
      bits = bits + 1;
    end else if (csB === 1'b0 && sclk !== sclkQ && bits > 0) begin
      // a phase-one leading edge comes before any sample and must not shift
      sh = (bits % 8 == 0) ? reply : {sh[6:0], 1'b0};
      miso = sh[7];
    end
    csQ = csB;
    sclkQ = sclk;
  end
endmodule // spicd_slave_model

/* spicd_top.sv */
// Summary of operation
// - Eight-bit divider register, read/write, resets to 0x1b.
// - Master serial clock equals core clock over two times (divider plus one).
// - Sixteen-bit control register, read/write, resets to zero.
// - Control bit 0 enables the serial port; cleared disables it.
// - Control bit 1 selects master (drives clock) or slave role.
// - Control bit 3 set: clock rests high; cleared: rests low.
// - Control bit 2 set: pulse at bit start; cleared: at bit end.
// - Control bit 5 set: least significant bit first; cleared: most first.
// - Bit 6 set: transmit write starts transfer; interrupt on transmit empty.
// - Bit 6 clear: receive read starts transfer; interrupt on receive full.
// - Transmit underflow sends zero with bit 7 set, else previous byte.
// - Receive overflow: bit 8 set overwrites unread byte, cleared discards new.
// - Master with bit 9 set stops driving chip select.
// - Bit 10 makes the slave data output open drain.
// - Bit 11 loops the data output internally back to the data input.
// - Bit 12 in master: bytes back to back, select held while data waits.
// - Bit 12 clear: single bytes, stall period before the next one.
// - Overflow flag sets when unread data is overwritten or a byte discarded.
// - Only transmit or receive interrupt bit raises interrupt; bit 6 chooses.
`timescale 1ns/1ps
module spicd_top #(
  parameter int DIV_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclkIn,
  output logic sclkOut,
  output logic sclkOen_b,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOen_b,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOen_b,
  input wire logic csIn_b,
  output logic csOut_b,
  output logic csOen_b,
  output logic spiIrq
);
  // =====================================================================
  // state machine of the master sequencer
  typedef enum logic [1:0] {MST_IDLE, MST_XFER, MST_STALL} spicd_mst_e;

  spicd_mst_e mstState;
  spicd_mst_e next_mstState;
  logic [DIV_W-1:0] divReg;
  logic [15:0] conReg;
  logic [7:0] txHold;
  logic [7:0] lastSent;
  logic [7:0] rxHold;
  logic txFull;
  logic txUnder;
  logic rxFull;
  logic rxOver;
  logic rxReadPend;
  logic [1:0] stallCnt;
  logic sclkPrev;
  logic irqReg;
  logic tick;

  spicd_shift_if sh ();

  // =====================================================================
  // control fields
  wire enable = conReg[spicd_pkg::CON_EN];
  wire master = conReg[spicd_pkg::CON_MASTER];
  wire cpha = conReg[spicd_pkg::CON_CPHA];
  wire cpol = conReg[spicd_pkg::CON_CPOL];
  wire txTrig = conReg[spicd_pkg::CON_TXTRIG];
  wire ufZero = conReg[spicd_pkg::CON_UFZERO];
  wire ovWrite = conReg[spicd_pkg::CON_OVWR];
  wire csDis = conReg[spicd_pkg::CON_CSDIS];
  wire oDrain = conReg[spicd_pkg::CON_ODRAIN];
  wire loopBack = conReg[spicd_pkg::CON_LOOP];
  wire contMode = conReg[spicd_pkg::CON_CONT];
  wire mstOn = enable & master;
  wire slvOn = enable & ~master;

  // =====================================================================
  // apb decode; every access completes with no wait state
  wire access = psel & penable;
  wire hitSta = (paddr == spicd_pkg::ADDR_STATUS);
  wire hitRx = (paddr == spicd_pkg::ADDR_RX);
  wire hitTx = (paddr == spicd_pkg::ADDR_TX);
  wire hitDiv = (paddr == spicd_pkg::ADDR_DIV);
  wire hitCon = (paddr == spicd_pkg::ADDR_CON);
  wire mapped = hitSta | hitRx | hitTx | hitDiv | hitCon;
  // status and receive are read only, transmit write only
  wire legal = hitDiv | hitCon | (hitTx & pwrite) | ((hitSta | hitRx) & ~pwrite);
  wire wrTx = access & pwrite & hitTx;
  wire wrDiv = access & pwrite & hitDiv;
  wire wrCon = access & pwrite & hitCon;
  wire rdRx = access & ~pwrite & hitRx;

  // =====================================================================
  // status word
  wire txIrq = ~txFull | txUnder;
  wire rxIrq = rxFull | rxOver;
  wire [7:0] statusWord = {2'b00, rxOver, rxIrq, rxFull, txUnder, txIrq, txFull};

  // read mux; unmapped or illegal reads return zero with an error
  assign prdata = !(psel && legal && !pwrite) ? 32'h0000_0000 :
                  hitSta ? {24'h00_0000, statusWord} :
                  hitRx ? {24'h00_0000, rxHold} :
                  hitDiv ? {{(32-DIV_W){1'b0}}, divReg} :
                  {16'h0000, conReg};
  assign pready = 1'b1;
  assign pslverr = access & ~(mapped & legal);

  // =====================================================================
  // byte to send: holding register, or the underflow substitute
  wire [7:0] sendByte = txFull ? txHold : (ufZero ? 8'h00 : lastSent);

  // slave framing and clock edges; pins are already in the core clock domain
  wire slvFramed = slvOn & ~csIn_b;
  wire slvStep = slvFramed & (sclkIn != sclkPrev);
  wire slvStart = slvFramed & ~sh.busy & ~sh.done;

  // master trigger: transmit write or receive read, per bit 6
  wire mstTrig = txTrig ? txFull : rxReadPend;
  wire mstStart = (mstState == MST_IDLE) & mstOn & mstTrig;
  // continuous mode chains the next byte with no stall
  wire mstChain = sh.done & contMode & txFull;
  wire load = mstStart | (mstState == MST_XFER & mstChain) | slvStart;

  // =====================================================================
  // master sequencer
  always_comb begin
    next_mstState = mstState;
    unique case (mstState)
      MST_IDLE: begin
        if (mstStart) next_mstState = MST_XFER;
      end
      MST_XFER: begin
        if (sh.done && !mstChain) next_mstState = MST_STALL;
      end
      MST_STALL: begin
        if (tick && stallCnt == spicd_pkg::STALL_TICKS - 2'h1) next_mstState = MST_IDLE;
      end
    endcase
    if (!mstOn) next_mstState = MST_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mstState <= MST_IDLE;
    end else begin
      mstState <= next_mstState;
    end
  end

  // stall ticks counted only while stalled
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stallCnt <= 2'h0;
    end else if (mstState != MST_STALL) begin
      stallCnt <= 2'h0;
    end else if (tick) begin
      stallCnt <= stallCnt + 2'h1;
    end
  end

  // =====================================================================
  // software registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      divReg <= spicd_pkg::DIV_RESET;
      conReg <= spicd_pkg::CON_RESET;
    end else begin
      if (wrDiv) divReg <= pwdata[DIV_W-1:0];
      if (wrCon) conReg <= pwdata[15:0] & spicd_pkg::CON_WMASK;
    end
  end

  // transmit side; a write landing with a load keeps the new byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txHold <= 8'h00;
      txFull <= 1'b0;
      txUnder <= 1'b0;
      lastSent <= 8'h00;
    end else begin
      if (wrTx) txHold <= pwdata[7:0];
      if (wrTx) txFull <= 1'b1;
      else if (load) txFull <= 1'b0;
      if (load && !txFull) txUnder <= 1'b1;  // set wins over the clearing write
      else if (wrTx) txUnder <= 1'b0;
      if (load) lastSent <= sendByte;
    end
  end

  // receive side; hardware set wins over a read that clears
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxHold <= 8'h00;
      rxFull <= 1'b0;
      rxOver <= 1'b0;
    end else begin
      if (sh.done && (!rxFull || rdRx || ovWrite)) rxHold <= sh.rxByte;
      if (sh.done) rxFull <= 1'b1;
      else if (rdRx) rxFull <= 1'b0;
      if (sh.done && rxFull && !rdRx) rxOver <= 1'b1;
      else if (rdRx) rxOver <= 1'b0;
    end
  end

  // a receive read in read-trigger mode requests one master byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxReadPend <= 1'b0;
    end else if (rdRx && mstOn && !txTrig) begin
      rxReadPend <= 1'b1;
    end else if (mstStart || !mstOn || txTrig) begin
      rxReadPend <= 1'b0;
    end
  end

  // previous slave clock level for edge detection, and interrupt select
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclkPrev <= 1'b0;
      irqReg <= 1'b0;
    end else begin
      sclkPrev <= sclkIn;
      irqReg <= enable & (txTrig ? txIrq : rxIrq);
    end
  end

  // =====================================================================
  // serial clock tick generator and shift engine
  spicd_clkgen #(
    .DIV_W(DIV_W)
  ) u_clkgen (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(mstState != MST_IDLE),
    .divisor(divReg),
    .tick(tick)
  );

  spicd_shifter u_shifter (
    .mclk(mclk),
    .rst_b(rst_b),
    .sh(sh)
  );

  // engine hookup; loopback feeds our own output back in
  assign sh.start = load;
  assign sh.abort = ~enable | (~master & csIn_b);
  assign sh.step = master ? (tick & (mstState == MST_XFER)) : slvStep;
  assign sh.cpha = cpha;
  assign sh.lsbFirst = conReg[spicd_pkg::CON_LSB];
  assign sh.txByte = sendByte;
  assign sh.dataIn = loopBack ? sh.dataOut : (master ? misoIn : mosiIn);

  // =====================================================================
  // pins; output enables are low while driving
  // the engine phase also toggles on slave steps, so only the master lets it reach the pin
  assign sclkOut = cpol ^ (sh.clkPhase & master);
  assign sclkOen_b = ~mstOn;
  assign mosiOut = sh.dataOut;
  assign mosiOen_b = ~mstOn;
  // open drain only pulls low, so the far end needs a pull-up
  assign misoOut = oDrain ? 1'b0 : sh.dataOut;
  assign misoOen_b = ~(slvFramed & (~oDrain | ~sh.dataOut));
  assign csOut_b = ~(mstState == MST_XFER);
  assign csOen_b = ~(mstOn & ~csDis);
  assign spiIrq = irqReg;
endmodule // spicd_top

/* spicd_top_tb.sv */
`timescale 1ns/1ps
// =====================================================================
// self-checking bench: apb master, far-side slave, seeded random data
module spicd_top_tb;
  localparam logic [31:0] STA = spicd_pkg::ADDR_STATUS;
  localparam logic [31:0] RXA = spicd_pkg::ADDR_RX;
  localparam logic [31:0] TXA = spicd_pkg::ADDR_TX;
  localparam logic [31:0] DVA = spicd_pkg::ADDR_DIV;
  localparam logic [31:0] CNA = spicd_pkg::ADDR_CON;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, spiIrq;
  logic [31:0] paddr, pwdata, prdata, rd, v;
  logic sclkIn, sclkOut, sclkOen_b, mosiIn, mosiOut, mosiOen_b;
  logic misoIn, misoOut, misoOen_b, csIn_b, csOut_b, csOen_b, slvMiso, err, smpFall;
  logic [7:0] reply, got, tx, r1, r2;
  int bits, mismatches, checkCount, n;
  // device pin wins only while its enable is low
  assign misoIn = misoOen_b ? slvMiso : misoOut;
  spicd_top uut (.*);
  spicd_slave_model slv (.sclk(sclkOut), .csB(csOut_b), .mosi(mosiOut), .reply(reply),
    .smpFall(smpFall), .miso(slvMiso), .got(got), .bits(bits));
  // =====================================================================
  // compare, bus and transfer helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checkCount++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 100) chk(32'h0, 32'h1, "bus hang");
  endtask
  task automatic rdChk(input logic [31:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask
  task automatic waitCs(input logic lvl);
    int k;
    k = 0;
    while (csOut_b !== lvl && k < 2000) begin
      @(posedge mclk);
      k++;
    end
    if (k == 2000) chk(32'h0, 32'h1, "select wait");
  endtask
  task automatic send(input logic [7:0] t, input logic [7:0] r);
    reply <= r;
    apb(1'b1, TXA, 32'(t));
    waitCs(1'b0);
    waitCs(1'b1);
  endtask
  // far-side master for the slave role, clock mode 0, four core cycles per half period
  task automatic slvByte(input logic [7:0] t, output logic [7:0] r);
    csIn_b <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosiIn <= t[i];
      repeat (4) @(posedge mclk);
      r[i] = misoOen_b | misoOut;  // released line reads as pulled up
      sclkIn <= 1'b1;
      repeat (4) @(posedge mclk);
      sclkIn <= 1'b0;
    end
    // select rises right after the last edge so no second byte gets loaded
    repeat (2) @(posedge mclk);
    csIn_b <= 1'b1;
  endtask
  function automatic logic [7:0] rev8(input logic [7:0] b);
    return {<<{b}};
  endfunction
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // =====================================================================
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    stopTest();
  end
  // main sequence; slave-side pins stay idle until the slave-role scenario
  initial begin
    {rst_b, psel, penable, pwrite, sclkIn, mosiIn, smpFall} = 7'h0;
    {paddr, pwdata, reply} = 72'h0;
    {csIn_b, mismatches, checkCount} = 65'h1_0000_0000_0000_0000;
    v = $urandom(32'hdf80);
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rdChk(DVA, 32'h1b, "div reset");
    rdChk(CNA, 32'h0, "con reset");
    apb(1'b1, CNA, 32'hffffffff);
    rdChk(CNA, 32'h1fef, "reserved bits");
    apb(1'b0, 32'hffff0a14, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    v = $urandom;
    apb(1'b1, DVA, v);
    rdChk(DVA, {24'h0, v[7:0]}, "div rw");
    apb(1'b1, DVA, 32'h1);
    for (int m = 0; m < 8; m++) begin
      smpFall <= m[0] ^ m[1];
      apb(1'b1, CNA, 32'h43 | (32'(m[1:0]) << 2) | (m[2] ? 32'h20 : 32'h0));
      tx = 8'($urandom);
      r1 = 8'($urandom);
      send(tx, r1);
      chk(32'(got), 32'(m[2] ? rev8(tx) : tx), "mosi byte");
      chk(32'(bits), 32'h8, "frame bits");
      rdChk(STA, 32'h1a, "done status");
      rdChk(RXA, 32'(m[2] ? rev8(r1) : r1), "miso byte");
    end
    for (int u = 0; u < 2; u++) begin
      apb(1'b1, CNA, 32'h3 | (32'(u) << 7));
      apb(1'b0, RXA, 32'h0);
      waitCs(1'b0);
      waitCs(1'b1);
      chk(32'(got), u ? 32'h0 : 32'(tx), "underflow byte");
      rdChk(STA, 32'h1e, "underflow status");
      apb(1'b0, RXA, 32'h0);
      waitCs(1'b0);
      waitCs(1'b1);
    end
    for (int o = 0; o < 2; o++) begin
      apb(1'b1, CNA, 32'h43 | (32'(o) << 8));
      apb(1'b0, RXA, 32'h0);
      r1 = 8'($urandom);
      r2 = 8'($urandom);
      send(8'h0f, r1);
      send(8'hf0, r2);
      rdChk(STA, 32'h3a, "overflow flag");
      rdChk(RXA, 32'(o ? r2 : r1), "overflow data");
    end
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, CNA, 32'h43 | (32'(c) << 12));
      tx = 8'($urandom);
      apb(1'b1, TXA, 32'h5a);
      waitCs(1'b0);
      apb(1'b1, TXA, 32'(tx));
      waitCs(1'b1);
      chk(32'(bits), c ? 32'h10 : 32'h8, "frame length");
      if (c == 0) waitCs(1'b0);
      waitCs(1'b1);
      chk(32'(got), 32'(tx), "second byte");
    end
    apb(1'b1, CNA, 32'h843);
    apb(1'b0, RXA, 32'h0);
    send(tx, ~tx);
    rdChk(RXA, 32'(tx), "loopback");
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, CNA, 32'h1 | (32'(s) << 10));
      tx = 8'($urandom);
      r1 = 8'($urandom);
      apb(1'b1, TXA, 32'(tx));
      slvByte(r1, r2);
      chk(32'(r2), 32'(tx), "slave miso");
      rdChk(RXA, 32'(r1), "slave mosi");
    end
    apb(1'b1, CNA, 32'h243);
    apb(1'b1, CNA, 32'h42);
    apb(1'b1, TXA, 32'h3c);
    n = 0;
    repeat (64) begin
      @(posedge mclk);
      if (csOut_b !== 1'b1) n++;
    end
    chk(32'(n), 32'h0, "disabled quiet");
    stopTest();
  end
endmodule // spicd_top_tb
